// *** design/legacy_timer_pkg.sv ***
/*
 * Package for the legacy interval timer: port offsets, command field
 * layout, modes, tick timing and the per-counter configuration struct.
 * Assumes the host bus presents 8-bit I/O accesses with a port number.
 */
package legacy_timer_pkg;

   localparam logic [7:0] SYSTEM_TICK_COUNT_PORT = 8'h40;
   localparam logic [7:0] MIDDLE_COUNT_PORT = 8'h41;
   localparam logic [7:0] TONE_COUNT_PORT = 8'h42;
   localparam logic [7:0] TIMER_COMMAND_PORT = 8'h43;

   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 6;
   localparam int RW_MSB = 5;
   localparam int RW_LSB = 4;
   localparam int MODE_MSB = 3;
   localparam int MODE_LSB = 1;
   localparam int BCD_BIT = 0;
   localparam int RB_NOCOUNT_BIT = 5;
   localparam int RB_NOSTATUS_BIT = 4;
   localparam int RB_CNT2_BIT = 3;
   localparam int RB_CNT0_BIT = 1;

   localparam logic [1:0] SEL_READBACK = 2'h3;
   localparam logic [1:0] SEL_MIDDLE = 2'h1;
   localparam logic [1:0] RW_LATCH = 2'h0;
   localparam logic [1:0] RW_LOW = 2'h1;
   localparam logic [1:0] RW_HIGH = 2'h2;
   localparam logic [1:0] RW_BOTH = 2'h3;

   localparam logic [7:0] UNUSED_READ_VALUE = 8'hff;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_HZ = 1_193_182;
   localparam int TICK_PERIOD_NS = 838;
   localparam int TICK_DIV_CYCLES = CLK_HZ / TICK_HZ;

   typedef enum logic [2:0] {
      MODE_EOC = 3'b000,
      MODE_ONESHOT = 3'b001,
      MODE_RATE = 3'b010,
      MODE_SQUARE = 3'b011,
      MODE_SWSTROBE = 3'b100,
      MODE_HWSTROBE = 3'b101
   } timer_mode_t;

   typedef struct packed {
      logic [1:0] rw;
      logic [2:0] mode;
      logic bcd;
   } counter_cfg_t;

endpackage

// *** design/tone_counter_unit.sv ***
/*
 * One 16-bit down counter with its mode logic, latches and byte
 * sequencing. Assumes write and read strobes are single-cycle pulses
 * already decoded for this counter, and tick_en is a one-cycle enable.
 */
module tone_counter_unit
   import legacy_timer_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Timing.
   input wire logic tick_en,
   input wire logic gate,
   // Command side.
   input wire logic cfg_we,
   input wire counter_cfg_t cfg_in,
   input wire logic latch_cnt,
   input wire logic latch_sts,
   // Data port.
   input wire logic data_we,
   input wire logic data_re,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic out_level
);

   counter_cfg_t cfg_r;
   logic [15:0] cnt_r, init_r, olatch_r;
   logic [7:0] low_r, sts_r;
   logic wr_hi_r, rd_hi_r, null_r, load_r, armed_r;
   logic cnt_latched_r, sts_latched_r, phase_r;
   logic [15:0] dec;
   logic zero_hit;

   // BCD decrement is treated as binary; the host rarely uses BCD here.
   assign dec = (cfg_r.mode == MODE_SQUARE) ? 16'h0002 : 16'h0001;
   assign zero_hit = armed_r && (cnt_r <= dec);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg_r <= '0;
      end else if (cfg_we) begin
         cfg_r <= cfg_in; // see RULE_09
      end
   end

   // A write merely stages the count; it loads on the next tick.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         init_r <= COUNT_RESET;
         low_r <= 8'h00;
         wr_hi_r <= 1'b0;
         null_r <= 1'b0;
         load_r <= 1'b0;
      end else if (cfg_we) begin
         wr_hi_r <= 1'b0;
         load_r <= 1'b0;
         null_r <= 1'b1;
      end else if (data_we) begin
         unique case (cfg_r.rw) // see RULE_06
            RW_LOW: begin
               init_r <= {8'h00, wdata};
               load_r <= 1'b1; // see RULE_07
            end
            RW_HIGH: begin
               init_r <= {wdata, 8'h00};
               load_r <= 1'b1;
            end
            default: begin
               if (!wr_hi_r) begin
                  low_r <= wdata;
                  wr_hi_r <= 1'b1;
               end else begin
                  init_r <= {wdata, low_r};
                  wr_hi_r <= 1'b0;
                  load_r <= 1'b1;
               end
            end
         endcase
      end else if (tick_en && load_r) begin
         load_r <= 1'b0; // see RULE_02
         null_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_r <= COUNT_RESET;
         armed_r <= 1'b0;
         out_level <= 1'b0;
         phase_r <= 1'b0;
      end else if (cfg_we) begin
         armed_r <= 1'b0;
         phase_r <= 1'b0;
         out_level <= (cfg_in.mode[2:1] != 2'b00); // see RULE_10
      end else if (tick_en && load_r) begin
         cnt_r <= init_r;
         armed_r <= 1'b1;
         // A fresh count starts a high half, so the next zero drops it.
         phase_r <= 1'b0; // see RULE_03
         if (cfg_r.mode == MODE_EOC || cfg_r.mode == MODE_ONESHOT) begin
            out_level <= 1'b0;
         end else begin
            out_level <= 1'b1;
         end
      end else if (tick_en && gate && armed_r) begin // see RULE_16
         unique case (cfg_r.mode)
            MODE_EOC: begin
               if (zero_hit) begin
                  out_level <= 1'b1; // see RULE_10
                  armed_r <= 1'b0;
               end
               cnt_r <= cnt_r - 16'h0001;
            end
            MODE_ONESHOT: begin
               out_level <= zero_hit; // see RULE_11
               cnt_r <= zero_hit ? init_r : cnt_r - 16'h0001;
            end
            MODE_RATE: begin
               out_level <= !zero_hit; // see RULE_12
               cnt_r <= zero_hit ? init_r : cnt_r - 16'h0001;
            end
            MODE_SQUARE: begin
               if (zero_hit) begin
                  out_level <= phase_r; // see RULE_03
                  phase_r <= !phase_r;
                  cnt_r <= init_r;
               end else begin
                  cnt_r <= cnt_r - 16'h0002;
               end
            end
            default: begin
               out_level <= !zero_hit; // see RULE_13
               if (zero_hit) begin
                  armed_r <= 1'b0;
               end
               cnt_r <= cnt_r - 16'h0001;
            end
         endcase
      end else if (tick_en && !armed_r && cfg_r.mode != MODE_EOC) begin
         out_level <= (cfg_r.mode != MODE_ONESHOT);
      end
   end

   // Latches hold the first capture until read or reprogrammed.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         olatch_r <= COUNT_RESET;
         sts_r <= 8'h00;
         cnt_latched_r <= 1'b0;
         sts_latched_r <= 1'b0;
         rd_hi_r <= 1'b0;
      end else if (cfg_we) begin
         cnt_latched_r <= 1'b0; // see RULE_20
         sts_latched_r <= 1'b0;
         rd_hi_r <= 1'b0;
      end else begin
         if (latch_cnt && !cnt_latched_r) begin
            olatch_r <= cnt_r; // see RULE_17
            cnt_latched_r <= 1'b1; // see RULE_18
         end
         if (latch_sts && !sts_latched_r) begin
            sts_r <= {out_level, null_r, cfg_r}; // see RULE_19
            sts_latched_r <= 1'b1; // see RULE_21
         end
         if (data_re) begin
            if (sts_latched_r) begin
               sts_latched_r <= 1'b0; // see RULE_22
            end else if (cfg_r.rw == RW_BOTH && !rd_hi_r) begin
               rd_hi_r <= 1'b1; // see RULE_15
            end else begin
               rd_hi_r <= 1'b0;
               cnt_latched_r <= 1'b0; // see RULE_20
            end
         end
      end
   end

   logic [15:0] src;
   assign src = cnt_latched_r ? olatch_r : cnt_r;

   // Combinational read data; sampled by the bus on the read strobe.
   always_comb begin
      if (sts_latched_r) begin
         rdata = sts_r;
      end else if (cfg_r.rw == RW_HIGH ||
                   (cfg_r.rw == RW_BOTH && rd_hi_r)) begin
         rdata = src[15:8]; // see RULE_14
      end else begin
         rdata = src[7:0];
      end
   end

   second_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      data_re && !sts_latched_r && cfg_r.rw == RW_BOTH && !rd_hi_r
      && !cfg_we |=> rd_hi_r) // see RULE_15
      else $error("second byte not selected after first read");
   first_latch_a: assert property (@(posedge sys_clk) disable iff (srst)
      latch_cnt && cnt_latched_r && !cfg_we && !data_re
      |=> olatch_r == $past(olatch_r)) // see RULE_18
      else $error("later latch overwrote held count");
   sts_first_a: assert property (@(posedge sys_clk) disable iff (srst)
      data_re && sts_latched_r && !cfg_we && !latch_cnt
      |=> !sts_latched_r && cnt_latched_r == $past(cnt_latched_r)
      && rd_hi_r == $past(rd_hi_r)) // see RULE_22
      else $error("status read consumed the count");
   load_tick_a: assert property (@(posedge sys_clk) disable iff (srst)
      tick_en && load_r && !cfg_we && !data_we |=> cnt_r == $past(init_r)
      && !load_r) // see RULE_02
      else $error("count not loaded on tick");
   gate_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      !gate && !load_r && !cfg_we |=> cnt_r == $past(cnt_r)) // see RULE_16
      else $error("count moved with gate low");
   eoc_high_a: assert property (@(posedge sys_clk) disable iff (srst)
      cfg_r.mode == MODE_EOC && out_level && !cfg_we && !load_r
      |=> out_level) // see RULE_10
      else $error("mode 0 output dropped");

endmodule // tone_counter_unit

// *** design/legacy_interval_timer.sv ***
/*
 * Top of the legacy interval timer: I/O port decode, tick divider and
 * the two implemented counters. Assumes io_wr and io_rd are one-cycle
 * strobes from the host bus on sys_clk, and the gate level is synced.
 */
// Overview of operation
// RULE_01 - Counters tick at 1.193 MHz only when working; the divider of 41 sys_clk cycles gives about 1.22 MHz.
// RULE_02 - Written count loads one tick later.
// RULE_03 - Square wave toggles output, decrements by two.
// RULE_04 - Tone frequency equals tick over initial count; an odd count gives tick over count plus one.
// RULE_05 - Host writes control word before any count.
// RULE_06 - Bits 5,4 pick low, high or both bytes.
// RULE_07 - New count accepted anytime, mode unchanged.
// RULE_08 - Host keeps two-byte writes uninterrupted.
// RULE_09 - Command port selects counter, mode, format, BCD; the BCD bit is only stored and shown in status, counting stays binary.
// RULE_10 - Mode 0 output rises at zero, stays high.
// RULE_11 - Mode 1 output high one tick at zero.
// RULE_12 - Mode 2 pulses low one tick, reloads.
// RULE_13 - Modes 4,5 pulse low one tick at expiry.
// RULE_14 - Simple reads at ports 40h and 42h.
// RULE_15 - Reads follow byte format, two reads.
// RULE_16 - Tone gate low stops tone counting.
// RULE_17 - Latch command captures count, counting continues.
// RULE_18 - Repeat latch ignored until first read.
// RULE_19 - Read-back captures count and status together.
// RULE_20 - Capture released on read or reprogram.
// RULE_21 - Repeat status capture ignored until read.
// RULE_22 - Status read first, then count bytes.
// RULE_23 - Middle counter commands and reads have no effect.
module legacy_interval_timer
   import legacy_timer_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Power state and gates.
   input wire logic working_state,
   input wire logic tone_gate,
   // Host I/O port.
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // Outputs.
   output logic system_tick_irq,
   output logic tone_out
);

   // The divider rounds down to whole sys_clk cycles, so the tick drifts
   // slightly from the ideal rate; a real part would use a fractional
   // divider from the crystal.
   logic [7:0] div_r;
   logic tick_en;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_r <= 8'h00;
      end else if (!working_state) begin
         div_r <= 8'h00; // see RULE_01
      end else if (div_r == 8'(TICK_DIV_CYCLES - 1)) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   assign tick_en = working_state && (div_r == 8'(TICK_DIV_CYCLES - 1));

   logic cmd_wr, ctl_word, rb_cmd;
   logic [1:0] sel;
   counter_cfg_t cfg_in;
   assign cmd_wr = io_wr && io_addr == TIMER_COMMAND_PORT;
   assign sel = io_wdata[SEL_MSB:SEL_LSB];
   assign rb_cmd = cmd_wr && sel == SEL_READBACK;
   assign ctl_word = cmd_wr && sel != SEL_READBACK
                     && io_wdata[RW_MSB:RW_LSB] != RW_LATCH;
   assign cfg_in = '{rw: io_wdata[RW_MSB:RW_LSB],
                     mode: io_wdata[MODE_MSB:MODE_LSB],
                     bcd: io_wdata[BCD_BIT]};

   logic [1:0] cfg_we, latch_c, latch_s, d_we, d_re;
   logic [7:0] rd0, rd2;

   // Counter index 0 is the system tick, index 1 the tone counter; the
   // middle select code 1 matches neither, so it does nothing.
   always_comb begin
      cfg_we[0] = ctl_word && sel == 2'h0; // see RULE_09
      cfg_we[1] = ctl_word && sel == 2'h2; // see RULE_23
      latch_c[0] = (cmd_wr && sel == 2'h0 && !ctl_word)
         || (rb_cmd && !io_wdata[RB_NOCOUNT_BIT]
             && io_wdata[RB_CNT0_BIT]); // see RULE_17
      latch_c[1] = (cmd_wr && sel == 2'h2 && !ctl_word)
         || (rb_cmd && !io_wdata[RB_NOCOUNT_BIT]
             && io_wdata[RB_CNT2_BIT]); // see RULE_19
      latch_s[0] = rb_cmd && !io_wdata[RB_NOSTATUS_BIT]
         && io_wdata[RB_CNT0_BIT];
      latch_s[1] = rb_cmd && !io_wdata[RB_NOSTATUS_BIT]
         && io_wdata[RB_CNT2_BIT];
      d_we[0] = io_wr && io_addr == SYSTEM_TICK_COUNT_PORT;
      d_we[1] = io_wr && io_addr == TONE_COUNT_PORT;
      d_re[0] = io_rd && io_addr == SYSTEM_TICK_COUNT_PORT; // see RULE_14
      d_re[1] = io_rd && io_addr == TONE_COUNT_PORT;
   end

   tone_counter_unit tick_cnt (
      .sys_clk(sys_clk),
      .srst(srst),
      .tick_en(tick_en),
      .gate(1'b1),
      .cfg_we(cfg_we[0]),
      .cfg_in(cfg_in),
      .latch_cnt(latch_c[0]),
      .latch_sts(latch_s[0]),
      .data_we(d_we[0]),
      .data_re(d_re[0]),
      .wdata(io_wdata),
      .rdata(rd0),
      .out_level(system_tick_irq) // see RULE_03
   );

   tone_counter_unit tone_cnt (
      .sys_clk(sys_clk),
      .srst(srst),
      .tick_en(tick_en),
      .gate(tone_gate), // see RULE_16
      .cfg_we(cfg_we[1]),
      .cfg_in(cfg_in),
      .latch_cnt(latch_c[1]),
      .latch_sts(latch_s[1]),
      .data_we(d_we[1]),
      .data_re(d_re[1]),
      .wdata(io_wdata),
      .rdata(rd2),
      .out_level(tone_out) // see RULE_04
   );

   // Read data is registered on the strobe so it stands afterwards.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         unique case (io_addr)
            SYSTEM_TICK_COUNT_PORT: io_rdata <= rd0;
            TONE_COUNT_PORT: io_rdata <= rd2;
            default: io_rdata <= UNUSED_READ_VALUE; // see RULE_23
         endcase
      end
   end

   no_tick_a: assert property (@(posedge sys_clk) disable iff (srst)
      !working_state |=> !tick_en [*8]) // see RULE_01
      else $error("tick outside working state");
   middle_dead_a: assert property (@(posedge sys_clk) disable iff (srst)
      cmd_wr && sel == SEL_MIDDLE |-> cfg_we == 2'b00) // see RULE_23
      else $error("middle counter command reached a counter");
   unused_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      io_rd && io_addr == MIDDLE_COUNT_PORT
      |=> io_rdata == UNUSED_READ_VALUE) // see RULE_23
      else $error("middle port returned data");

endmodule // legacy_interval_timer

// *** bench/host_model.sv ***
/*
 * Host processor model that issues 8-bit I/O port writes and reads.
 * Assumes the timer takes a strobe on the rising sys_clk edge and
 * registers read data at that same edge.
 */
module host_model
   import legacy_timer_pkg::*;
(
   // Clock.
   input wire logic sys_clk,
   // Host I/O port.
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_addr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
   end

   // Each byte goes whole in one strobe; callers send the control word
   // first and both count bytes with no other writer between.
   task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      #1;
      io_wr = 1'b1;
      io_addr = addr;
      io_wdata = data;
      @(posedge sys_clk);
      #1;
      io_wr = 1'b0;
      // Released lines show the inverse so stale values never look valid.
      io_addr = ~addr;
      io_wdata = ~data;
   endtask

   // Reads follow the programmed format, one byte per call.
   task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      #1;
      io_rd = 1'b1;
      io_addr = addr;
      @(posedge sys_clk);
      #1;
      io_rd = 1'b0;
      io_addr = ~addr;
      data = io_rdata;
   endtask
endmodule // host_model

// *** bench/testbench.sv ***
/*
 * Self-checking bench for the legacy interval timer, with the host
 * model on the I/O port. Assumes the tick is TICK_DIV_CYCLES clocks.
 */
module testbench;
   import legacy_timer_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int T = TICK_DIV_CYCLES;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic working_state = 1'b1;
   logic tone_gate = 1'b1;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_addr;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic system_tick_irq;
   logic tone_out;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   logic [2:0] d_modes [4] = '{3'd1, 3'd2, 3'd4, 3'd5};

   always #10 sys_clk = ~sys_clk;

   legacy_interval_timer u_dut (
      .sys_clk(sys_clk), .srst(srst), .working_state(working_state),
      .tone_gate(tone_gate), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .system_tick_irq(system_tick_irq), .tone_out(tone_out)
   );

   host_model u_host (
      .sys_clk(sys_clk), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata)
   );

   task automatic print_verdict();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         n_mismatch = n_mismatch + 1;
         print_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      u_host.io_read(a, lo);
      u_host.io_read(a, hi);
      v = {hi, lo};
   endtask

   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      u_host.io_write(a, v[7:0]);
      u_host.io_write(a, v[15:8]);
   endtask

   // Waits for an output to reach lvl, then counts how long it stays.
   task automatic pulse(input bit tone, input logic lvl, output int w,
                        output int n);
      w = 0;
      n = 0;
      while ((tone ? tone_out : system_tick_irq) !== lvl && w < 1000) begin
         @(posedge sys_clk);
         #1;
         w = w + 1;
      end
      while ((tone ? tone_out : system_tick_irq) === lvl && n < 1000) begin
         @(posedge sys_clk);
         #1;
         n = n + 1;
      end
   endtask

   initial begin
      logic [15:0] v;
      logic [15:0] v2;
      logic [15:0] cnt;
      logic [7:0] s;
      logic lvl;
      int w;
      int n;
      int n2;
      int t0;
      int d;
      void'($urandom(29));
      repeat (10) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      check({io_rdata, 6'h00, system_tick_irq, tone_out}, 16'h0000);
      // Mode 0 terminal count: low from programming, high after load + N.
      u_host.io_write(TIMER_COMMAND_PORT, 8'h30);
      check({15'h0, system_tick_irq}, 16'h0000);
      wr16(SYSTEM_TICK_COUNT_PORT, 16'h0005);
      pulse(1'b0, 1'b1, w, n);
      check({15'h0, w >= 5 * T - 2 && w <= 6 * T + 2}, 16'h1);
      check(16'(n), 16'd1000);
      // Square wave: each half lasts count/2 ticks.
      u_host.io_write(TIMER_COMMAND_PORT, 8'h36);
      wr16(SYSTEM_TICK_COUNT_PORT, 16'd10);
      pulse(1'b0, 1'b1, w, n);
      pulse(1'b0, 1'b0, w, n);
      check(16'(n), 16'(5 * T));
      pulse(1'b0, 1'b1, w, n);
      check(16'(n), 16'(5 * T));
      // A new count without a control word keeps the square mode.
      wr16(SYSTEM_TICK_COUNT_PORT, 16'd20);
      pulse(1'b0, 1'b0, w, n);
      pulse(1'b0, 1'b1, w, n);
      pulse(1'b0, 1'b0, w, n);
      check(16'(n), 16'(10 * T));
      // Tone period equals count ticks, untouched by the middle counter.
      u_host.io_write(TIMER_COMMAND_PORT, 8'hb6);
      wr16(TONE_COUNT_PORT, 16'd8);
      for (int i = 0; i < 2; i++) begin
         pulse(1'b1, 1'b1, w, n);
         pulse(1'b1, 1'b0, w, n);
         pulse(1'b1, 1'b1, w, n2);
         check(16'(n + n2), 16'(8 * T));
         u_host.io_write(TIMER_COMMAND_PORT, 8'h50);
         u_host.io_write(MIDDLE_COUNT_PORT, 8'h03);
      end
      u_host.io_read(MIDDLE_COUNT_PORT, s);
      check({8'h00, s}, {8'h00, UNUSED_READ_VALUE});
      // One-tick pulses of modes 1, 2, 4 and 5 with low-byte counts.
      foreach (d_modes[i]) begin
         lvl = (d_modes[i] == 3'd1);
         u_host.io_write(TIMER_COMMAND_PORT, {5'b10010, d_modes[i][1:0], 1'b0}
                         | {4'h0, d_modes[i][2], 3'h0});
         check({15'h0, tone_out}, 16'(!lvl));
         u_host.io_write(TONE_COUNT_PORT, 8'h05);
         pulse(1'b1, lvl, w, n);
         check(16'(n), 16'(T));
      end
      // Gate low and the idle power state both freeze the tone count.
      u_host.io_write(TIMER_COMMAND_PORT, 8'hb4);
      cnt = 16'($urandom_range(16'h7fff, 16'h0400));
      wr16(TONE_COUNT_PORT, cnt);
      repeat (300) @(posedge sys_clk);
      #1;
      tone_gate = 1'b0;
      repeat (100) @(posedge sys_clk);
      rd16(TONE_COUNT_PORT, v);
      check({15'h0, v < cnt}, 16'h1);
      u_host.io_write(TIMER_COMMAND_PORT, 8'h80);
      rd16(TONE_COUNT_PORT, v2);
      check(v2, v);
      @(posedge sys_clk);
      #1;
      tone_gate = 1'b1;
      working_state = 1'b0;
      repeat (100) @(posedge sys_clk);
      rd16(TONE_COUNT_PORT, v);
      repeat (200) @(posedge sys_clk);
      rd16(TONE_COUNT_PORT, v2);
      check(v2, v);
      @(posedge sys_clk);
      #1;
      working_state = 1'b1;
      tone_gate = 1'b0;
      // A second latch before the read is ignored.
      u_host.io_write(TIMER_COMMAND_PORT, 8'h34);
      wr16(SYSTEM_TICK_COUNT_PORT, 16'($urandom_range(16'hffff, 16'h8000)));
      repeat (100) @(posedge sys_clk);
      t0 = cyc;
      u_host.io_write(TIMER_COMMAND_PORT, 8'h00);
      repeat (200) @(posedge sys_clk);
      u_host.io_write(TIMER_COMMAND_PORT, 8'h00);
      rd16(SYSTEM_TICK_COUNT_PORT, v);
      d = (cyc - t0) / T;
      u_host.io_write(TIMER_COMMAND_PORT, 8'h00);
      rd16(SYSTEM_TICK_COUNT_PORT, v2);
      n = int'(v - v2);
      check({15'h0, n >= d - 1 && n <= d + 1}, 16'h1);
      // Read-back of both counters, count and status, issued twice.
      rd16(TONE_COUNT_PORT, cnt);
      u_host.io_write(TIMER_COMMAND_PORT, 8'hca);
      u_host.io_write(TIMER_COMMAND_PORT, 8'hca);
      u_host.io_read(TONE_COUNT_PORT, s);
      check({8'h00, s & 8'h7f}, 16'h0034);
      rd16(TONE_COUNT_PORT, v);
      check(v, cnt);
      repeat (100) @(posedge sys_clk);
      u_host.io_read(SYSTEM_TICK_COUNT_PORT, s);
      check({8'h00, s & 8'h7f}, 16'h0034);
      rd16(SYSTEM_TICK_COUNT_PORT, v);
      repeat (200) @(posedge sys_clk);
      rd16(SYSTEM_TICK_COUNT_PORT, v2);
      check({15'h0, int'(v - v2) > 3}, 16'h1);
      rd16(TONE_COUNT_PORT, v);
      check(v, cnt);
      // A high-byte-only count loads with a zero low byte; gate is low.
      v = {8'h00, 8'($urandom_range(255, 1))};
      u_host.io_write(TIMER_COMMAND_PORT, 8'ha4);
      u_host.io_write(TONE_COUNT_PORT, v[7:0]);
      repeat (2 * T) @(posedge sys_clk);
      u_host.io_read(TONE_COUNT_PORT, s);
      check({8'h00, s}, v);
      print_verdict();
   end
endmodule // testbench
